// ---- common/asc_pkg.sv ----
// shared constants and state types for the asynchronous serial channel
package asc_pkg;
    // register offsets on the byte port
    localparam logic [2:0] ASC_OFS_DATA = 3'h0;
    localparam logic [2:0] ASC_OFS_IER = 3'h1;
    localparam logic [2:0] ASC_OFS_IIR = 3'h2;
    localparam logic [2:0] ASC_OFS_LCR = 3'h3;
    localparam logic [2:0] ASC_OFS_MCR = 3'h4;
    localparam logic [2:0] ASC_OFS_LSR = 3'h5;
    localparam logic [2:0] ASC_OFS_MSR = 3'h6;
    localparam logic [2:0] ASC_OFS_SCR = 3'h7;
    // line and modem control field positions
    localparam int ASC_LCR_STB = 2;
    localparam int ASC_LCR_PEN = 3;
    localparam int ASC_LCR_EPS = 4;
    localparam int ASC_LCR_STICK = 5;
    localparam int ASC_LCR_BREAK = 6;
    localparam int ASC_LCR_DIVISOR_ACCESS_SEL = 7;
    localparam int ASC_MCR_LOOP = 4;
    // values after reset
    localparam logic [7:0] ASC_LCR_RESET = 8'h00;
    localparam logic [3:0] ASC_IER_RESET = 4'h0;
    localparam logic [4:0] ASC_MCR_RESET = 5'h00;
    localparam logic [15:0] ASC_DIV_RESET = 16'h000c;
    // clock rates; the reference tick is made by a phase accumulator
    localparam logic [26:0] ASC_CLK_HZ = 27'd125_000_000;
    localparam logic [26:0] ASC_REF_HZ = 27'd1_843_200;
    // sample ticks per bit and stop lengths in sample ticks
    localparam logic [3:0] ASC_MID_START = 4'h7;
    localparam logic [3:0] ASC_LAST_SAMPLE = 4'hf;
    localparam logic [5:0] ASC_STOP_ONE = 6'h10;
    localparam logic [5:0] ASC_STOP_HALF = 6'h18;
    localparam logic [5:0] ASC_STOP_TWO = 6'h20;
    // interrupt source identifiers, highest priority first
    localparam logic [1:0] ASC_ID_LINE = 2'h3;
    localparam logic [1:0] ASC_ID_RX = 2'h2;
    localparam logic [1:0] ASC_ID_TX = 2'h1;
    localparam logic [1:0] ASC_ID_MODEM = 2'h0;
    localparam int ASC_RX_FIFO_DEPTH = 4;
    localparam int ASC_RX_WORD = 11;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_START = 3'b001,
        TX_DATA = 3'b010,
        TX_PAR = 3'b011,
        TX_STOP = 3'b100
    } asc_tx_state_type;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_START = 3'b001,
        RX_DATA = 3'b010,
        RX_PAR = 3'b011,
        RX_STOP = 3'b100,
        RX_BRK = 3'b101
    } asc_rx_state_type;
endpackage

// ---- rtl/asc_fifo.sv ----
// small first-in first-out buffer with valid and ready on both sides
`timescale 1ns/100ps
module asc_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 4
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    // depth must be a power of two; the extra pointer bit tells full from empty
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    wire push = i_valid && o_ready;
    wire pop = o_valid && i_ready;
    wire ptr_wrap = wr_q[AW] != rd_q[AW];
    wire ptr_same = wr_q[AW-1:0] == rd_q[AW-1:0];

    assign o_ready = !(ptr_wrap && ptr_same);
    assign o_valid = !(!ptr_wrap && ptr_same);
    assign o_data = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= i_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= push ? wr_q + 1'b1 : wr_q;
            rd_q <= pop ? rd_q + 1'b1 : rd_q;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    fifo_full_a: assert property (!o_ready |-> !o_valid == 1'b0)
        else $error("fifo full while empty");
endmodule // asc_fifo

// ---- rtl/asc_serial_channel.sv ----
// asynchronous serial channel: byte registers, transmitter, receiver, modem lines
`timescale 1ns/100ps
// Function
// - frame is start bit, 5 to 8 data bits, optional parity, then stop bits
// - stop select clear gives one stop; set gives 1.5 for 5-bit, else two
// - divisor 1..65535 on the reference clock makes the 16x bit clock
// - receiver uses the same 16x clock, so both directions share one rate
// - access bit clear: offset 0 reads received byte, writes transmit byte
// - access bit set: offsets 0 and 1 reach divisor low and high bytes
// - offsets 2..7 reach ident, line ctrl, modem ctrl, line status, modem status, scratch
// - enable bits 0..3 gate rx, tx empty, line and modem interrupts
// - ident bit 0 low when pending, bits 2:1 source, bits 7:3 zero
// - line control bits 1:0 choose five to eight data bits
// - bit 2 stop count, 3 parity on, 4 even, 5 stick parity
// - bit 6 forces break on the line, bit 7 is the divisor access bit
// - modem control bits 0..4 drive dtr, rts, out1, out2 and loopback
// - line status reports ready, overrun, parity, framing, break, empties
// - modem status flags line changes and shows current line levels
module asc_serial_channel (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_irq,
    input wire logic i_sin,
    output logic o_sout,
    input wire logic i_cts_n,
    input wire logic i_dsr_n,
    input wire logic i_ri_n,
    input wire logic i_dcd_n,
    output logic o_dtr_n,
    output logic o_rts_n,
    output logic o_out1_n,
    output logic o_out2_n
);
    asc_pkg::asc_tx_state_type tx_state_q, tx_state_d;
    asc_pkg::asc_rx_state_type rx_state_q, rx_state_d;
    logic [7:0] lcr_q, scr_q, thr_q, rbr_q, rdata_q, tx_shift_q, rx_shift_q;
    logic [3:0] ier_q, lsr_err_q, msr_delta_q, ms_prev_q, ms_m_q, ms_s_q;
    logic [4:0] mcr_q;
    logic [15:0] div_q, divcnt_q;
    logic [26:0] phase_q;
    logic [5:0] tx_tick_q;
    logic [3:0] rx_tick_q;
    logic [2:0] tx_bitn_q, rx_bitn_q;
    logic tx_holding_empty_q, dr_q, tx_par_q, rx_par_q, rx_zero_q, sout_q, irq_q;
    logic sin_m_q, sin_s_q;
    logic fifo_in_ready, fifo_out_valid;
    logic [10:0] fifo_out;

    // parity over the active data bits only
    function automatic logic asc_parity(input logic [7:0] d, input logic [7:0] line_control);
        logic [7:0] m;
        m = 8'(8'hff >> (2'h3 - line_control[1:0]));
        if (line_control[asc_pkg::ASC_LCR_STICK]) begin
            return !line_control[asc_pkg::ASC_LCR_EPS];
        end
        return line_control[asc_pkg::ASC_LCR_EPS] ? ^(d & m) : ~^(d & m);
    endfunction

    // register decode
    wire divisor_access_sel = lcr_q[asc_pkg::ASC_LCR_DIVISOR_ACCESS_SEL];
    wire loop = mcr_q[asc_pkg::ASC_MCR_LOOP];
    wire parity_on = lcr_q[asc_pkg::ASC_LCR_PEN];
    wire at_data = i_addr == asc_pkg::ASC_OFS_DATA;
    wire at_ier = i_addr == asc_pkg::ASC_OFS_IER;
    wire wr_thr = i_wr && at_data && !divisor_access_sel;
    wire wr_dll = i_wr && at_data && divisor_access_sel;
    wire wr_dlm = i_wr && at_ier && divisor_access_sel;
    wire wr_ier = i_wr && at_ier && !divisor_access_sel;
    wire wr_lcr = i_wr && i_addr == asc_pkg::ASC_OFS_LCR;
    wire wr_mcr = i_wr && i_addr == asc_pkg::ASC_OFS_MCR;
    wire wr_scr = i_wr && i_addr == asc_pkg::ASC_OFS_SCR;
    wire rd_rbr = i_rd && at_data && !divisor_access_sel;
    wire rd_lsr = i_rd && i_addr == asc_pkg::ASC_OFS_LSR;
    wire rd_msr = i_rd && i_addr == asc_pkg::ASC_OFS_MSR;

    // reference tick at 1.8432 MHz out of the system clock, jitter one cycle
    wire [26:0] phase_sum = phase_q + asc_pkg::ASC_REF_HZ;
    wire ref_tick = phase_sum >= asc_pkg::ASC_CLK_HZ;
    wire [26:0] phase_d = ref_tick ? phase_sum - asc_pkg::ASC_CLK_HZ : phase_sum;
    // a divisor of zero behaves as one
    wire div_hit = (divcnt_q + 16'h1) >= div_q;
    wire tick16 = ref_tick && div_hit;

    // frame shape from line control
    wire [2:0] last_idx = 3'(3'h4 + {1'b0, lcr_q[1:0]});
    wire [5:0] stop_len = !lcr_q[asc_pkg::ASC_LCR_STB] ? asc_pkg::ASC_STOP_ONE :
        (lcr_q[1:0] == 2'h0) ? asc_pkg::ASC_STOP_HALF : asc_pkg::ASC_STOP_TWO;
    wire [5:0] bit_len = (tx_state_q == asc_pkg::TX_STOP) ? stop_len : asc_pkg::ASC_STOP_ONE;

    // transmitter
    wire tx_bit_end = tick16 && (tx_tick_q == bit_len - 6'h1);
    wire tx_load = (tx_state_q == asc_pkg::TX_IDLE) && !tx_holding_empty_q;
    wire tx_line = (tx_state_q == asc_pkg::TX_START) ? 1'b0 :
        (tx_state_q == asc_pkg::TX_DATA) ? tx_shift_q[0] :
        (tx_state_q == asc_pkg::TX_PAR) ? tx_par_q : 1'b1;
    wire tx_out = lcr_q[asc_pkg::ASC_LCR_BREAK] ? 1'b0 : tx_line;
    wire tx_shift_empty = tx_state_q == asc_pkg::TX_IDLE;

    always_comb begin
        tx_state_d = tx_state_q;
        unique case (tx_state_q)
            asc_pkg::TX_IDLE: if (!tx_holding_empty_q) tx_state_d = asc_pkg::TX_START;
            asc_pkg::TX_START: if (tx_bit_end) tx_state_d = asc_pkg::TX_DATA;
            asc_pkg::TX_DATA: if (tx_bit_end && tx_bitn_q == last_idx) begin
                tx_state_d = parity_on ? asc_pkg::TX_PAR : asc_pkg::TX_STOP;
            end
            asc_pkg::TX_PAR: if (tx_bit_end) tx_state_d = asc_pkg::TX_STOP;
            asc_pkg::TX_STOP: if (tx_bit_end) tx_state_d = asc_pkg::TX_IDLE;
            default: tx_state_d = asc_pkg::TX_IDLE;
        endcase
    end

    wire [5:0] tx_tick_d = (tx_state_d != tx_state_q || tx_bit_end) ? 6'h0 :
        tick16 ? tx_tick_q + 6'h1 : tx_tick_q;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tx_shift_q <= 8'h00;
            tx_bitn_q <= 3'h0;
            tx_par_q <= 1'b0;
        end else if (tx_load) begin
            tx_shift_q <= thr_q;
            tx_bitn_q <= 3'h0;
            tx_par_q <= asc_parity(thr_q, lcr_q);
        end else if (tx_state_q == asc_pkg::TX_DATA && tx_bit_end) begin
            tx_shift_q <= tx_shift_q >> 1;
            tx_bitn_q <= tx_bitn_q + 3'h1;
        end
    end

    // receiver input, looped back from the transmitter in test mode
    wire rx_in = loop ? tx_out : sin_s_q;
    wire rx_samp = tick16 && rx_tick_q == asc_pkg::ASC_LAST_SAMPLE;
    wire rx_push = (rx_state_q == asc_pkg::RX_STOP) && rx_samp;
    wire [7:0] rx_data = 8'(rx_shift_q >> (3'h7 - last_idx));
    wire rx_pe = parity_on && (rx_par_q != asc_parity(rx_data, lcr_q));
    wire rx_fe = !rx_in;
    wire rx_bi = rx_zero_q && !rx_in;

    always_comb begin
        rx_state_d = rx_state_q;
        unique case (rx_state_q)
            asc_pkg::RX_IDLE: if (tick16 && !rx_in) rx_state_d = asc_pkg::RX_START;
            asc_pkg::RX_START: if (tick16 && rx_tick_q == asc_pkg::ASC_MID_START) begin
                rx_state_d = rx_in ? asc_pkg::RX_IDLE : asc_pkg::RX_DATA;
            end
            asc_pkg::RX_DATA: if (rx_samp && rx_bitn_q == last_idx) begin
                rx_state_d = parity_on ? asc_pkg::RX_PAR : asc_pkg::RX_STOP;
            end
            asc_pkg::RX_PAR: if (rx_samp) rx_state_d = asc_pkg::RX_STOP;
            // a held-low line is one break, not a stream of empty frames
            asc_pkg::RX_STOP: if (rx_samp) begin
                rx_state_d = rx_in ? asc_pkg::RX_IDLE : asc_pkg::RX_BRK;
            end
            asc_pkg::RX_BRK: if (rx_in) rx_state_d = asc_pkg::RX_IDLE;
            default: rx_state_d = asc_pkg::RX_IDLE;
        endcase
    end

    wire [3:0] rx_tick_d = (rx_state_d != rx_state_q) ? 4'h0 :
        tick16 ? rx_tick_q + 4'h1 : rx_tick_q;
    wire rx_bit = rx_samp && (rx_state_q == asc_pkg::RX_DATA ||
        rx_state_q == asc_pkg::RX_PAR);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_shift_q <= 8'h00;
            rx_bitn_q <= 3'h0;
            rx_par_q <= 1'b0;
            rx_zero_q <= 1'b0;
        end else if (rx_state_q == asc_pkg::RX_START) begin
            rx_bitn_q <= 3'h0;
            rx_zero_q <= 1'b1;
        end else if (rx_bit) begin
            rx_zero_q <= rx_zero_q && !rx_in;
            if (rx_state_q == asc_pkg::RX_DATA) begin
                rx_shift_q <= {rx_in, rx_shift_q[7:1]};
                rx_bitn_q <= rx_bitn_q + 3'h1;
            end else begin
                rx_par_q <= rx_in;
            end
        end
    end

    // received words wait here; a full buffer turns a new word into overrun
    wire fifo_pop = fifo_out_valid && !dr_q;
    asc_fifo #(
        .WIDTH(asc_pkg::ASC_RX_WORD),
        .DEPTH(asc_pkg::ASC_RX_FIFO_DEPTH)
    ) u_rx_fifo (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_valid(rx_push),
        .o_ready(fifo_in_ready),
        .i_data({rx_bi, rx_fe, rx_pe, rx_data}),
        .o_valid(fifo_out_valid),
        .i_ready(!dr_q),
        .o_data(fifo_out)
    );

    // status flags; a new event wins over a clearing read in the same cycle
    wire overrun = rx_push && !fifo_in_ready;
    wire [3:0] err_set = {fifo_pop ? fifo_out[10:8] : 3'h0, overrun};
    wire [3:0] lsr_err_d = err_set | (rd_lsr ? 4'h0 : lsr_err_q);
    wire dr_d = fifo_pop | (dr_q && !rd_rbr);
    wire tx_holding_empty_d = !wr_thr && (tx_holding_empty_q || tx_load);

    // modem lines, active high after inversion
    wire [3:0] ms_pins = {~i_dcd_n, ~i_ri_n, ~i_dsr_n, ~i_cts_n};
    wire [3:0] ms_loop = {mcr_q[3], mcr_q[2], mcr_q[0], mcr_q[1]};
    wire [3:0] ms_now = loop ? ms_loop : ms_s_q;
    wire [3:0] ms_set = {ms_now[3] ^ ms_prev_q[3], ms_prev_q[2] && !ms_now[2],
        ms_now[1:0] ^ ms_prev_q[1:0]};
    wire [3:0] msr_delta_d = ms_set | (rd_msr ? 4'h0 : msr_delta_q);

    // interrupt source by priority
    wire line_irq = ier_q[2] && |lsr_err_q;
    wire rx_irq = ier_q[0] && dr_q;
    wire tx_irq = ier_q[1] && tx_holding_empty_q;
    wire ms_irq = ier_q[3] && |msr_delta_q;
    wire irq_pend = line_irq || rx_irq || tx_irq || ms_irq;
    wire [1:0] irq_id = line_irq ? asc_pkg::ASC_ID_LINE : rx_irq ? asc_pkg::ASC_ID_RX :
        tx_irq ? asc_pkg::ASC_ID_TX : asc_pkg::ASC_ID_MODEM;
    wire [7:0] interrupt_identification = {5'h00, irq_id, !irq_pend};
    wire [7:0] line_status = {1'b0, tx_shift_empty, tx_holding_empty_q, lsr_err_q, dr_q};

    // read selection
    wire [7:0] rd_mux =
        at_data ? (divisor_access_sel ? div_q[7:0] : rbr_q) :
        at_ier ? (divisor_access_sel ? div_q[15:8] : {4'h0, ier_q}) :
        (i_addr == asc_pkg::ASC_OFS_IIR) ? interrupt_identification :
        (i_addr == asc_pkg::ASC_OFS_LCR) ? lcr_q :
        (i_addr == asc_pkg::ASC_OFS_MCR) ? {3'h0, mcr_q} :
        (i_addr == asc_pkg::ASC_OFS_LSR) ? line_status :
        (i_addr == asc_pkg::ASC_OFS_MSR) ? {ms_now, msr_delta_q} : scr_q;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lcr_q <= asc_pkg::ASC_LCR_RESET;
            ier_q <= asc_pkg::ASC_IER_RESET;
            mcr_q <= asc_pkg::ASC_MCR_RESET;
            div_q <= asc_pkg::ASC_DIV_RESET;
            scr_q <= 8'h00;
            thr_q <= 8'h00;
        end else begin
            lcr_q <= wr_lcr ? i_wdata : lcr_q;
            ier_q <= wr_ier ? i_wdata[3:0] : ier_q;
            mcr_q <= wr_mcr ? i_wdata[4:0] : mcr_q;
            div_q[7:0] <= wr_dll ? i_wdata : div_q[7:0];
            div_q[15:8] <= wr_dlm ? i_wdata : div_q[15:8];
            scr_q <= wr_scr ? i_wdata : scr_q;
            thr_q <= wr_thr ? i_wdata : thr_q;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            phase_q <= 27'h0;
            divcnt_q <= 16'h0;
            tx_state_q <= asc_pkg::TX_IDLE;
            tx_tick_q <= 6'h0;
            rx_state_q <= asc_pkg::RX_IDLE;
            rx_tick_q <= 4'h0;
        end else begin
            phase_q <= phase_d;
            divcnt_q <= !ref_tick ? divcnt_q : div_hit ? 16'h0 : divcnt_q + 16'h1;
            tx_state_q <= tx_state_d;
            tx_tick_q <= tx_tick_d;
            rx_state_q <= rx_state_d;
            rx_tick_q <= rx_tick_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tx_holding_empty_q <= 1'b1;
            dr_q <= 1'b0;
            rbr_q <= 8'h00;
            lsr_err_q <= 4'h0;
            msr_delta_q <= 4'h0;
            ms_prev_q <= 4'h0;
            rdata_q <= 8'h00;
            irq_q <= 1'b0;
            sout_q <= 1'b1;
        end else begin
            tx_holding_empty_q <= tx_holding_empty_d;
            dr_q <= dr_d;
            rbr_q <= fifo_pop ? fifo_out[7:0] : rbr_q;
            lsr_err_q <= lsr_err_d;
            msr_delta_q <= msr_delta_d;
            ms_prev_q <= ms_now;
            rdata_q <= i_rd ? rd_mux : rdata_q;
            irq_q <= irq_pend;
            sout_q <= loop ? 1'b1 : tx_out;
        end
    end

    // pin synchronisers, second stage only is read
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sin_m_q <= 1'b1;
            sin_s_q <= 1'b1;
            ms_m_q <= 4'h0;
            ms_s_q <= 4'h0;
        end else begin
            sin_m_q <= i_sin;
            sin_s_q <= sin_m_q;
            ms_m_q <= ms_pins;
            ms_s_q <= ms_m_q;
        end
    end

    assign o_rdata = rdata_q;
    assign o_irq = irq_q;
    assign o_sout = sout_q;
    assign o_dtr_n = ~mcr_q[0];
    assign o_rts_n = ~mcr_q[1];
    assign o_out1_n = ~mcr_q[2];
    assign o_out2_n = ~mcr_q[3];

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    sequence tx_start_done;
        tx_state_q == asc_pkg::TX_START && tx_bit_end;
    endsequence

    tx_frame_order_a: assert property (tx_start_done |=> tx_state_q == asc_pkg::TX_DATA)
        else $error("start bit not followed by data");
    stop_length_a: assert property (tx_state_q == asc_pkg::TX_STOP && tx_bit_end |->
        tx_tick_q == (!lcr_q[2] ? 6'h0f : (lcr_q[1:0] == 2'h0) ? 6'h17 : 6'h1f))
        else $error("stop bit length wrong");
    tick_spacing_a: assert property (tick16 |=> !tick16 [*8])
        else $error("sample ticks too close");
    rx_on_tick_a: assert property (rx_state_q == asc_pkg::RX_IDLE &&
        rx_state_d == asc_pkg::RX_START |-> tick16)
        else $error("receiver left idle off tick");
    data_read_a: assert property (rd_rbr && dr_q |=> !dr_q)
        else $error("data ready not cleared by read");
    div_high_a: assert property (wr_dlm |=> div_q[15:8] == $past(i_wdata))
        else $error("divisor high byte not written");
    ident_read_a: assert property (i_rd && i_addr == asc_pkg::ASC_OFS_IIR |=>
        o_rdata[7:3] == 5'h00 && o_rdata[0] == !$past(irq_pend))
        else $error("ident register read wrong");
    thr_write_a: assert property (wr_thr |=> !tx_holding_empty_q)
        else $error("holding empty not cleared");
    loop_idle_a: assert property (loop |=> o_sout)
        else $error("line not idle in loopback");
    break_force_a: assert property (lcr_q[6] && !loop |=> !o_sout)
        else $error("break not forced");
    cts_delta_a: assert property (ms_now[0] != ms_prev_q[0] |=> msr_delta_q[0])
        else $error("cts change not flagged");
endmodule // asc_serial_channel

// ---- tb/asc_line_model.sv ----
// serial line partner: sends frames into the channel and captures its frames
`timescale 1ns/100ps
module asc_line_model #(
    parameter int BIT_NS = 8681
) (
    input wire logic i_line,
    output logic o_line
);
    logic [10:0] cap_q[$];
    logic [10:0] sh;
    initial o_line = 1'b1;
    // start low, then bits lsb first, back to mark
    task automatic send_frame(input logic [10:0] bits, input int cnt);
        o_line = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < cnt; i++) begin
            o_line = bits[i];
            #(BIT_NS);
        end
        o_line = 1'b1;
    endtask
    // sample mid-bit; trailing idle shows up as ones
    always begin
        @(negedge i_line);
        #(BIT_NS / 2);
        for (int i = 0; i < 11; i++) begin
            #(BIT_NS);
            sh[i] = i_line;
        end
        cap_q.push_back(sh);
    end
endmodule // asc_line_model

// ---- tb/asc_serial_channel_tb.sv ----
// self-checking bench for the asynchronous serial channel
`timescale 1ns/100ps
module asc_serial_channel_tb;
    logic i_clk = 1'b0, i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_sin;
    logic [2:0] i_addr = 3'h0;
    logic [7:0] i_wdata = 8'h00, o_rdata, d, lctl, stat;
    logic o_irq, o_sout, o_dtr_n, o_rts_n, o_out1_n, o_out2_n;
    logic i_cts_n = 1'b1, i_dsr_n = 1'b1, i_ri_n = 1'b1, i_dcd_n = 1'b1;
    logic [15:0] exp_q[$];
    logic [15:0] note;
    logic rd_taken = 1'b0;
    logic [7:0] modes[3] = '{8'h03, 8'h1a, 8'h0c};
    int failures = 0, total_checks = 0, cycles = 0;
    always #4 i_clk = ~i_clk;
    asc_serial_channel uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
        .i_sin(i_sin), .o_sout(o_sout), .i_cts_n(i_cts_n), .i_dsr_n(i_dsr_n),
        .i_ri_n(i_ri_n), .i_dcd_n(i_dcd_n), .o_dtr_n(o_dtr_n), .o_rts_n(o_rts_n),
        .o_out1_n(o_out1_n), .o_out2_n(o_out2_n));
    asc_line_model line (.i_line(o_sout), .o_line(i_sin));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // mask in the upper byte; a zero mask means read without comparing
    task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] v);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        exp_q.push_back({m, v & m});
        @(posedge i_clk);
        i_rd <= 1'b0;
    endtask
    task automatic wait_status();
        for (int i = 0; i < 50; i++) begin
            rd(3'h5, 8'h00, 8'h00);
            @(posedge i_clk);
            #1;
            stat = o_rdata;
            if (stat[0] === 1'b1) return;
        end
        check("status wait", 16'h0000, 16'h0001);
    endtask
    // data, parity and stop bits as they travel, lsb first, idle ones after
    function automatic logic [10:0] frame(input logic [7:0] l, input logic [7:0] v);
        int n = 5 + l[1:0];
        logic [7:0] m = 8'hff >> (3 - l[1:0]);
        logic [10:0] f = '1;
        for (int i = 0; i < n; i++) f[i] = v[i];
        if (l[3]) f[n] = ^(v & m) ^ ~l[4];
        return f;
    endfunction
    always @(posedge i_clk) begin
        rd_taken <= i_rd;
        if (rd_taken) begin
            note = exp_q.pop_front();
            if (note[15:8] != 8'h00) check("rdata", {8'h00, o_rdata & note[15:8]}, {8'h00, note[7:0]});
        end
        cycles++;
        // frames at divisor 1 take about 1100 cycles a bit; eight frames plus waits fit
        if (cycles == 95000) begin
            failures++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(32'h3a9a));
        repeat (12) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rd(3'h3, 8'hff, 8'h00);
        rd(3'h1, 8'hff, 8'h00);
        rd(3'h2, 8'hff, 8'h01);
        rd(3'h4, 8'hff, 8'h00);
        rd(3'h5, 8'hff, 8'h60);
        d = 8'($urandom());
        wr(3'h7, d);
        wr(3'h5, 8'h00);
        rd(3'h7, 8'hff, d);
        rd(3'h5, 8'hff, 8'h60);
        wr(3'h3, 8'h80);
        rd(3'h0, 8'hff, 8'h0c);
        wr(3'h1, 8'hab);
        rd(3'h1, 8'hff, 8'hab);
        wr(3'h1, 8'h00);
        wr(3'h0, 8'h01);
        rd(3'h0, 8'hff, 8'h01);
        wr(3'h3, 8'h03);
        rd(3'h1, 8'hff, 8'h00);
        wr(3'h4, 8'h03);
        i_cts_n <= 1'b0;
        repeat (6) @(posedge i_clk);
        #1;
        check("modem outputs", {12'h000, o_dtr_n, o_rts_n, o_out1_n, o_out2_n}, 16'h0003);
        rd(3'h6, 8'h11, 8'h11);
        rd(3'h6, 8'h11, 8'h10);
        wr(3'h1, 8'h01);
        foreach (modes[k]) begin
            lctl = modes[k];
            wr(3'h3, lctl);
            d = 8'($urandom());
            wr(3'h0, d);
            rd(3'h5, 8'h40, 8'h00);
            for (int i = 0; i < 20000 && line.cap_q.size() == 0; i++) @(posedge i_clk);
            check("tx frame", {5'h00, line.cap_q.pop_front()}, {5'h00, frame(lctl, d)});
            d = 8'($urandom());
            line.send_frame(frame(lctl, d), 6 + lctl[1:0] + lctl[3]);
            wait_status();
            check("rx status", {11'h000, stat[4:0]}, 16'h0001);
            check("irq", {15'h0000, o_irq}, 16'h0001);
            rd(3'h2, 8'hff, 8'h04);
            rd(3'h0, 8'hff >> (3 - lctl[1:0]), d);
            rd(3'h5, 8'h01, 8'h00);
            #1;
            check("irq", {15'h0000, o_irq}, 16'h0000);
        end
        // wrong parity, then a low stop bit, in the five-bit odd mode
        line.send_frame(frame(lctl, d) ^ 11'h020, 7);
        wait_status();
        check("parity flag", {11'h000, stat[4:0]}, 16'h0005);
        rd(3'h0, 8'h00, 8'h00);
        line.send_frame(frame(lctl, d | 8'h01) ^ 11'h040, 7);
        wait_status();
        check("stop flag", {11'h000, stat[4:0]}, 16'h0009);
        rd(3'h0, 8'h00, 8'h00);
        wr(3'h3, 8'h4c);
        repeat (2) @(posedge i_clk);
        #1;
        check("break line", {15'h0000, o_sout}, 16'h0000);
        repeat (4) @(posedge i_clk);
        tally_and_finish();
    end
endmodule // asc_serial_channel_tb
